/* design/bfo_synth.sv */
// The register addresses and the strobed register port were chosen for this implementation.
module bfo_synth (
  input  wire logic                  clk,            // 25 MHz system clock
  input  wire logic                  rst_n,          // Sync reset
  input  wire logic                  ce,             // Clock enable
  input  wire logic                  refIn,          // 1 MHz reference pin
  input  wire logic                  vcoIn,          // Oscillator feedback pin
  input  wire logic                  serClk,         // Serial link clock pin
  input  wire logic                  serData,        // Serial data pin
  input  wire logic                  serEnable,      // Load enable pin
  input  wire logic                  disableIn,      // Oscillator disable pin
  input  wire bfo_pkg::bfo_bus_req_t busReq,         // Register request
  output logic [31:0]                busRdata,       // Read data
  output logic                       refOut,         // Spare reference out
  output logic                       pumpUpPulseN,   // Pump-up, low active
  output logic                       pumpDownPulseN, // Pump-down, low active
  output logic                       bfoOut,         // Divided output
  output logic                       lockDet,        // High when unlocked
  output logic                       loadCheckOutput,// Word check pulse
  output logic                       irq             // Interrupt level
);
  import bfo_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int NPIN = 6;
  logic [NPIN-1:0] pinMeta_r;
  logic [NPIN-1:0] pinSync_r;
  logic [NPIN-1:0] pinPrev_r;
  logic            refS;
  logic            vcoS;
  logic            sckS;
  logic            sdS;
  logic            enS;
  logic            disS;
  logic            refEdge;
  logic            vcoEdge;
  logic            sckRise;
  logic            enFall;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
      pinPrev_r <= '0;
    end else if (ce) begin
      pinMeta_r <= {disableIn, serEnable, serData, serClk, vcoIn, refIn};
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
    end
  end

  assign {disS, enS, sdS, sckS, vcoS, refS} = pinSync_r;
  assign refEdge = refS & ~pinPrev_r[0];
  assign vcoEdge = vcoS & ~pinPrev_r[1];
  assign sckRise = sckS & ~pinPrev_r[2];
  assign enFall  = ~enS & pinPrev_r[4];

  ////////////////////////////////////////////////////////////////////////
  // Reference divider
  localparam logic [9:0] REF_MOD = 10'(REF_DIV);
  logic [9:0] refCnt;
  logic       refWrap;

  bfo_div_counter #(.W(10)) uRefDiv (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .step    (refEdge),
    .modulus (REF_MOD),
    .count   (refCnt),
    .wrap    (refWrap)
  );

  ////////////////////////////////////////////////////////////////////////
  // Feedback divider: prescaler then swallow/program counter
  logic       vcoStep;
  logic [8:0] progMod_r;
  logic [6:0] swallow_r;
  logic [8:0] progCnt;
  logic       fbWrap;
  logic [6:0] preMod;
  logic [6:0] preCnt;
  logic       preWrap;

  // Disable shorts the inputs of both dividers
  assign vcoStep = vcoEdge & ~disS;
  // First A cycles of each frame divide by 101, the rest by 100
  assign preMod = (9'(swallow_r) > progCnt) ? 7'(PRE_HIGH) : 7'(PRE_LOW);

  bfo_div_counter #(.W(7)) uPrescale (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .step    (vcoStep),
    .modulus (preMod),
    .count   (preCnt),
    .wrap    (preWrap)
  );

  bfo_div_counter #(.W(9)) uProgDiv (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .step    (preWrap),
    .modulus (progMod_r),
    .count   (progCnt),
    .wrap    (fbWrap)
  );

  ////////////////////////////////////////////////////////////////////////
  // Output divider by 100: toggle every 50 oscillator edges
  logic [5:0] outCnt;
  logic       outWrap;
  logic       bfoOut_nxt;

  bfo_div_counter #(.W(6)) uOutDiv (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .step    (vcoStep),
    .modulus (6'(OUT_HALF)),
    .count   (outCnt),
    .wrap    (outWrap)
  );

  assign bfoOut_nxt = outWrap ? ~bfoOut : bfoOut;

  ////////////////////////////////////////////////////////////////////////
  // Serial tuning link
  logic [SER_WORD_W-1:0] shift_r;
  logic [SER_WORD_W-1:0] shift_nxt;
  logic [SER_CNT_W-1:0]  bitCnt_r;
  logic [SER_CNT_W-1:0]  bitCnt_nxt;
  logic [SER_WORD_W-1:0] word_r;
  bfo_tune_word_t        tw;
  logic                  shiftEn;
  logic                  digitsOk;
  logic                  wordOk;
  logic                  loadStb;
  logic                  badStb;
  logic [6:0]            lowPart;
  logic [8:0]            newP;
  logic [6:0]            newA;

  // Bits count only while the enable line is open
  assign shiftEn   = sckRise & enS;
  assign shift_nxt = SER_MSB_FIRST ? {shift_r[SER_WORD_W-2:0], sdS}
                                   : {sdS, shift_r[SER_WORD_W-1:1]};
  assign bitCnt_nxt = (bitCnt_r == SER_CNT_W'(SER_WORD_W)) ? bitCnt_r
                                                           : bitCnt_r + SER_CNT_W'(1);
  assign tw       = shift_r;
  assign digitsOk = (tw.khz < 4'h9 + 4'h1) && (tw.hund < 4'h9 + 4'h1) && (tw.tens < 4'h9 + 4'h1);
  assign wordOk   = digitsOk && (bitCnt_r == SER_CNT_W'(SER_WORD_W));
  // Transfer happens only at the end of the enable pulse
  assign loadStb  = enFall & wordOk;
  assign badStb   = enFall & ~wordOk;

  // N = 45500 - offset, split into 100*P + A without a divider
  assign lowPart = 7'(tw.hund) * 7'd10 + 7'(tw.tens);
  assign newP = tw.neg ? 9'(P_CENTRE) + 9'(tw.khz)
                       : 9'(P_CENTRE) - 9'(tw.khz) - 9'(lowPart != 7'd0);
  assign newA = tw.neg ? lowPart
                       : ((lowPart == 7'd0) ? 7'd0 : 7'(PRE_LOW) - lowPart);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_r   <= '0;
      bitCnt_r  <= '0;
      word_r    <= '0;
      progMod_r <= 9'(P_CENTRE);
      swallow_r <= 7'd0;
    end else if (ce) begin
      if (shiftEn) begin
        shift_r  <= shift_nxt;
        bitCnt_r <= bitCnt_nxt;
      end else if (enFall) begin
        bitCnt_r <= '0;
      end
      if (loadStb) begin
        word_r    <= shift_r;
        progMod_r <= newP;
        swallow_r <= newA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Check pulse after a good load
  localparam logic [4:0] CHK_LEN = 5'(CHECK_PULSE_CYC);
  logic [4:0] chkCnt_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chkCnt_r        <= '0;
      loadCheckOutput <= 1'b0;
    end else if (ce) begin
      if (loadStb) begin
        chkCnt_r        <= CHK_LEN - 5'd1;
        loadCheckOutput <= 1'b1;
      end else if (chkCnt_r != 5'd0) begin
        chkCnt_r <= chkCnt_r - 5'd1;
      end else begin
        loadCheckOutput <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase-frequency comparator
  logic upQ_r;
  logic dnQ_r;
  logic upNxt;
  logic dnNxt;
  logic upSet;
  logic dnSet;

  // Reference first raises up, feedback first raises down; both clear
  assign upSet = upQ_r | refWrap;
  assign dnSet = dnQ_r | fbWrap;
  // Coincident edges leave both idle
  assign upNxt = upSet & ~dnSet;
  assign dnNxt = dnSet & ~upSet;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      upQ_r          <= 1'b0;
      dnQ_r          <= 1'b0;
      pumpUpPulseN   <= 1'b1;
      pumpDownPulseN <= 1'b1;
    end else if (ce) begin
      upQ_r          <= upNxt;
      dnQ_r          <= dnNxt;
      pumpUpPulseN   <= ~upNxt;
      pumpDownPulseN <= ~dnNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lock detector: a run of narrow error pulses means locked
  logic [6:0] errW_r;
  logic [2:0] good_r;
  logic       pulseEnd;
  logic       tooWide;

  assign pulseEnd = (upQ_r | dnQ_r) & ~(upNxt | dnNxt);
  assign tooWide  = errW_r >= 7'(LOCK_WIN_CYC);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      errW_r  <= '0;
      good_r  <= '0;
      lockDet <= 1'b1;
    end else if (ce) begin
      errW_r <= (upNxt | dnNxt) ? (tooWide ? errW_r : errW_r + 7'd1) : 7'd0;
      if (disS || tooWide) begin
        good_r  <= '0;
        lockDet <= 1'b1;
      end else if (pulseEnd) begin
        if (good_r == 3'(LOCK_GOOD)) begin
          lockDet <= 1'b0;
        end else begin
          good_r <= good_r + 3'd1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file and interrupts
  logic [IRQ_W-1:0] status_r;
  logic [IRQ_W-1:0] irqEn_r;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clrMask;
  logic             lockPrev_r;
  logic [15:0]      divN;
  logic [31:0]      rdMux;

  assign events  = {badStb, lockDet & ~lockPrev_r, loadStb};
  assign clrMask = (busReq.wr && busReq.addr == ADDR_IRQ_CLR) ? busReq.wdata[IRQ_W-1:0] : '0;
  assign divN    = 16'(progMod_r) * 16'd100 + 16'(swallow_r);
  assign rdMux   = (busReq.addr == ADDR_STATUS) ? 32'(status_r)
                 : (busReq.addr == ADDR_IRQ_EN) ? 32'(irqEn_r)
                 : (busReq.addr == ADDR_DIV_N)  ? 32'(divN)
                 : (busReq.addr == ADDR_WORD)   ? 32'(word_r)
                 : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_r   <= '0;
      irqEn_r    <= IRQ_EN_RST;
      lockPrev_r <= 1'b1;
      busRdata   <= 32'h0000_0000;
      irq        <= 1'b0;
      refOut     <= 1'b0;
      bfoOut     <= 1'b0;
    end else if (ce) begin
      // New event beats a clear in the same cycle
      status_r   <= (status_r & ~clrMask) | events;
      lockPrev_r <= lockDet;
      if (busReq.wr && busReq.addr == ADDR_IRQ_EN) begin
        irqEn_r <= busReq.wdata[IRQ_W-1:0];
      end
      busRdata <= busReq.rd ? rdMux : 32'h0000_0000;
      irq      <= |(((status_r & ~clrMask) | events) & irqEn_r);
      refOut   <= refS;
      bfoOut   <= bfoOut_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_ref_wrap_count: assert property (
    refWrap |-> refCnt == 10'd999
  ) else $error("reference divider wrapped off count");

  chk_n_in_range: assert property (
    divN >= 16'(N_MIN) && divN <= 16'(N_MAX)
  ) else $error("feedback ratio out of range");

  chk_n_formula: assert property (
    ce && loadStb |=> divN == ($past(tw.neg)
      ? 16'(N_CENTRE) + 16'($past(tw.khz)) * 16'd100 + 16'($past(lowPart))
      : 16'(N_CENTRE) - 16'($past(tw.khz)) * 16'd100 - 16'($past(lowPart)))
  ) else $error("ratio does not match offset word");

  chk_match_idle: assert property (
    ce && refWrap && fbWrap && !upQ_r && !dnQ_r |=> pumpUpPulseN && pumpDownPulseN
  ) else $error("pump active on matched edges");

  chk_up_on_ref: assert property (
    ce && refWrap && !fbWrap && !dnQ_r |=> !pumpUpPulseN && pumpDownPulseN
  ) else $error("reference lead gave no pump-up");

  chk_dn_on_fb: assert property (
    ce && fbWrap && !refWrap && !upQ_r |=> !pumpDownPulseN && pumpUpPulseN
  ) else $error("feedback lead gave no pump-down");

  chk_pumps_exclusive: assert property (
    !(!pumpUpPulseN && !pumpDownPulseN)
  ) else $error("both pump outputs low");

  chk_disable_blocks: assert property (
    disS |-> !vcoStep ##1 ce |-> $stable(outCnt) && $stable(preCnt)
  ) else $error("divider clocked while disabled");

  chk_check_pulse: assert property (
    ce && loadStb |=> loadCheckOutput [*8]
  ) else $error("check pulse missing after load");

  chk_load_at_end: assert property (
    ce && $changed(word_r) |-> $past(enFall) && $past(wordOk)
  ) else $error("word loaded outside enable end");

  chk_out_toggle: assert property (
    $changed(bfoOut) |-> $past(outWrap)
  ) else $error("output toggled without wrap");

endmodule // bfo_synth

/* shared/bfo_pkg.sv */
// Notes on behaviour
// - Reference input divided by exactly 1000 gives the comparison rate.
// - Feedback ratio N, prescaler 100/101 plus counter, spans 44501 to 46499.
// - N equals 45500 minus the signed offset; bigger offset, lower output.
// - Offset is signed digits of 1 kHz, 100 Hz, 10 Hz: 10 Hz steps.
// - Oscillator divided by 100 gives the injection output.
// - Serial bits follow the link clock, accepted only while enable is high.
// - Matched frequency and phase: both pump outputs rest high.
// - Feedback slower than reference: low pulses on pump-up, width tracks error.
// - Feedback faster than reference: low pulses on pump-down instead.
// - Error pulses shrink as loop converges; then both outputs rest high.
// - Disable blocks both prescaler and output divider clocking.
// - Lock indicator low while tracking; controller watches it for faults.
// - Check output pulses high after a good word is decoded into N.
package bfo_pkg;

  localparam int CLK_PERIOD_NS = 40;

  // Divider figures
  localparam int REF_DIV  = 1000;
  localparam int PRE_LOW  = 100;
  localparam int PRE_HIGH = 101;
  localparam int OUT_HALF = 50;
  localparam int N_CENTRE = 45500;
  localparam int N_MIN    = 44500;
  localparam int N_MAX    = 46500;
  localparam int P_CENTRE = 455;

  // Serial word: sign, then three BCD digits
  localparam int SER_WORD_W = 13;
  localparam int SER_CNT_W  = 4;
  localparam bit SER_MSB_FIRST = 1'b1;

  // Timing
  localparam int CHECK_PULSE_NS  = 1000;
  localparam int CHECK_PULSE_CYC = (CHECK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_WIN_NS     = 2000;
  localparam int LOCK_WIN_CYC    = (LOCK_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_GOOD       = 4;

  // Register map
  localparam logic [4:0] ADDR_STATUS = 5'h00;
  localparam logic [4:0] ADDR_IRQ_EN = 5'h04;
  localparam logic [4:0] ADDR_IRQ_CLR = 5'h08;
  localparam logic [4:0] ADDR_DIV_N  = 5'h0C;
  localparam logic [4:0] ADDR_WORD   = 5'h10;

  localparam int IRQ_W      = 3;
  localparam int ST_LOAD    = 0;
  localparam int ST_UNLOCK  = 1;
  localparam int ST_BADWORD = 2;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;

  typedef struct packed {
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bfo_bus_req_t;

  typedef struct packed {
    logic       neg;
    logic [3:0] khz;
    logic [3:0] hund;
    logic [3:0] tens;
  } bfo_tune_word_t;

endpackage

/* design/bfo_div_counter.sv */
module bfo_div_counter #(
  parameter int W = 10
) (
  input  wire logic         clk,     // System clock
  input  wire logic         rst_n,   // Sync reset
  input  wire logic         ce,      // Clock enable
  input  wire logic         step,    // Count event
  input  wire logic [W-1:0] modulus, // Division ratio
  output logic      [W-1:0] count,   // Current count
  output logic              wrap     // Last state, step taken
);
  logic [W-1:0] count_nxt;

  // A ratio shrunk under a running count still wraps at once
  assign wrap      = step & (count >= modulus - W'(1));
  assign count_nxt = wrap ? '0 : (step ? count + W'(1) : count);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= '0;
    end else if (ce) begin
      count <= count_nxt;
    end
  end
endmodule // bfo_div_counter

/* verif/bfo_ctrl_model.sv */
module bfo_ctrl_model (
  output logic serClk,   // Link clock, still between frames
  output logic serData,  // Tuning bits
  output logic serEnable // Load window
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HALF_NS = 160;

  initial begin
    serClk    = 1'b0;
    serData   = 1'b0;
    serEnable = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // Frame sender; a long gap gives the slow controller
  task automatic send(input logic [12:0] word, input int nBits, input int gapNs);
    int i;
    #7;
    serEnable = 1'b1;
    #(HALF_NS);
    for (i = nBits - 1; i >= 0; i--) begin
      serData = word[i];
      #(HALF_NS);
      serClk = 1'b1;
      #(HALF_NS);
      serClk = 1'b0;
    end
    #(HALF_NS + gapNs);
    serEnable = 1'b0;
    // Released line: no pull, so show the inverse
    serData = ~serData;
  endtask
endmodule // bfo_ctrl_model

/* verif/bfo_synth_divider_pfd_tb.sv */
module bfo_synth_divider_pfd_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bfo_pkg::*;

  logic         clk, rst_n, ce, refIn, vcoIn, disableIn;
  wire          serClk, serData, serEnable;
  bfo_bus_req_t busReq;
  logic [31:0]  busRdata;
  logic         refOut, pumpUpPulseN, pumpDownPulseN, bfoOut, lockDet, loadCheckOutput, irq;
  logic [31:0]  expQ[$];
  logic [31:0]  du;
  logic [12:0]  w, tbl[3];
  logic [31:0]  lastN;
  logic         rdQ, bfoPrev, refPrev;
  int           badCount, checked, toggles, refRises, seed, t0, n, i;

  bfo_synth i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .refIn(refIn), .vcoIn(vcoIn),
    .serClk(serClk), .serData(serData), .serEnable(serEnable), .disableIn(disableIn),
    .busReq(busReq), .busRdata(busRdata), .refOut(refOut), .pumpUpPulseN(pumpUpPulseN),
    .pumpDownPulseN(pumpDownPulseN), .bfoOut(bfoOut), .lockDet(lockDet),
    .loadCheckOutput(loadCheckOutput), .irq(irq));

  bfo_ctrl_model i_ctrl (.serClk(serClk), .serData(serData), .serEnable(serEnable));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checked %0d, mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge clk);
  endtask

  // Each task lowers the other strobe and idle lowers both, so back-to-back reads keep rd high
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    busReq.addr <= a;
    busReq.rd   <= 1'b1;
    busReq.wr   <= 1'b0;
    expQ.push_back(e);
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    busReq.addr  <= a;
    busReq.wdata <= d;
    busReq.wr    <= 1'b1;
    busReq.rd    <= 1'b0;
    @(posedge clk);
  endtask

  task automatic idle();
    busReq.wr <= 1'b0;
    busReq.rd <= 1'b0;
    step(2);
  endtask

  task automatic pulses(input int c);
    repeat (c) begin
      vcoIn <= 1'b1;
      step(3);
      vcoIn <= 1'b0;
      step(3);
    end
  endtask

  function automatic logic [31:0] expN(input logic [12:0] v);
    int off;
    off = v[11:8] * 100 + v[7:4] * 10 + v[3:0];
    return 32'(v[12] ? N_CENTRE + off : N_CENTRE - off);
  endfunction

  task automatic load(input logic [12:0] v, input int nb, input logic good, input int gap);
    int k;
    i_ctrl.send(v, nb, gap);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (loadCheckOutput !== 1'b1 && k < 40);
    chkBit(loadCheckOutput, good, "check pulse");
    if (loadCheckOutput !== good) conclude();
    if (good) begin
      k = 0;
      while (loadCheckOutput === 1'b1 && k < 60) begin
        @(posedge clk);
        k++;
      end
      chkWord(32'(k), 32'(CHECK_PULSE_CYC), "pulse width");
      if (k >= 60) conclude();
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // Read checker and output watchers
  always @(posedge clk) begin
    if (rdQ === 1'b1 && expQ.size() > 0) chkWord(busRdata, expQ.pop_front(), "read data");
    rdQ     <= busReq.rd;
    bfoPrev <= bfoOut;
    if (bfoOut !== bfoPrev) toggles++;
    refPrev <= refOut;
    if (refOut === 1'b1 && refPrev === 1'b0) refRises++;
    if (serEnable === 1'b1 && loadCheckOutput !== 1'b0) chkBit(loadCheckOutput, 1'b0, "early load");
  end

  initial begin
    seed = 32'h5f9b_93c3;
    {rst_n, refIn, vcoIn, disableIn, rdQ, bfoPrev, refPrev} = '0;
    ce = 1'b1;
    busReq = '0;
    {badCount, checked, toggles, refRises} = '0;
    tbl[0] = 13'h0500;
    tbl[1] = 13'h0999;
    tbl[2] = 13'h1999;
    step(5);
    rst_n <= 1'b1;
    step(4);
    chkBit(pumpUpPulseN, 1'b1, "up idle");
    chkBit(pumpDownPulseN, 1'b1, "down idle");
    rd(ADDR_DIV_N, 32'(N_CENTRE));
    rd(5'h14, 32'h0000_0000);
    rd(ADDR_STATUS, 32'h0000_0000);
    wr(ADDR_IRQ_EN, 32'h0000_0001);
    rd(ADDR_IRQ_EN, 32'h0000_0001);
    idle();
    $display("test reset and map done");
    // Self-test style loads: word sent, check output read back
    for (i = 0; i < 6; i++) begin
      du = $unsigned($random(seed));
      w = (i < 3) ? tbl[i] : {du[31], 4'(du[7:0] % 10), 4'(du[15:8] % 10), 4'(du[23:16] % 10)};
      load(w, 13, 1'b1, (i % 2) * 2000);
      chkBit(irq, 1'b1, "irq raised");
      lastN = expN(w);
      rd(ADDR_DIV_N, lastN);
      rd(ADDR_WORD, {19'h0, w});
      rd(ADDR_STATUS, 32'h0000_0001);
      wr(ADDR_IRQ_CLR, 32'h0000_0001);
      idle();
      chkBit(irq, 1'b0, "irq cleared");
    end
    $display("test good words done");
    load(13'h00A0, 13, 1'b0, 0);
    load(13'h0123, 12, 1'b0, 0);
    rd(ADDR_DIV_N, lastN);
    rd(ADDR_STATUS, 32'h0000_0004);
    idle();
    chkBit(irq, 1'b0, "irq masked");
    wr(ADDR_IRQ_EN, 32'h0000_0004);
    idle();
    chkBit(irq, 1'b1, "irq bad word");
    wr(ADDR_IRQ_CLR, 32'h0000_0004);
    idle();
    chkBit(irq, 1'b0, "irq bad cleared");
    $display("test bad words done");
    // Clock enable low: oscillator edges must not be counted at all
    ce <= 1'b0;
    t0 = toggles;
    pulses(60);
    step(10);
    chkWord(32'(toggles - t0), 32'h0000_0000, "frozen toggles");
    ce <= 1'b1;
    t0 = toggles;
    pulses(200);
    step(10);
    chkWord(32'(toggles - t0), 32'h0000_0004, "output toggles");
    disableIn <= 1'b1;
    step(4);
    t0 = toggles;
    pulses(200);
    step(10);
    chkWord(32'(toggles - t0), 32'h0000_0000, "disabled toggles");
    chkBit(lockDet, 1'b1, "lock while disabled");
    disableIn <= 1'b0;
    $display("test output divider done");
    // Feedback stays idle, so the reference must lead
    t0 = refRises;
    n = 0;
    while (pumpUpPulseN === 1'b1 && n < 1100) begin
      refIn <= 1'b1;
      step(3);
      refIn <= 1'b0;
      step(3);
      n++;
    end
    chkWord(32'(n), 32'(REF_DIV), "reference rises");
    if (pumpUpPulseN !== 1'b0) conclude();
    chkBit(pumpDownPulseN, 1'b1, "down quiet");
    step(60);
    chkBit(pumpUpPulseN, 1'b0, "up held");
    chkBit(lockDet, 1'b1, "unlock shown");
    chkWord(32'(refRises - t0), 32'(n), "spare reference rises");
    $display("test comparator done");
    conclude();
  end
endmodule // bfo_synth_divider_pfd_tb
